// ---- img_defs.svh ----
// Purpose: Offsets, field positions and reset values of the interrupt gating block
// Assumes: 8-bit registers reached by an internal register port
// Notes:   Included by bare name
`ifndef IMG_DEFS_SVH
`define IMG_DEFS_SVH

// ==========================================================
// Register offsets
`define IMG_ADDR_MASK0     8'h07
`define IMG_ADDR_MASK1     8'h08
`define IMG_ADDR_MASK2     8'h09
`define IMG_ADDR_FLAG0     8'h0A
`define IMG_ADDR_FLAG1     8'h0B
`define IMG_ADDR_FLAG2     8'h0C

// ==========================================================
// Fields and reset values
`define IMG_SELF_CLR_BIT   7
`define IMG_MASK0_WMASK    8'h8B
`define IMG_MASK1_WMASK    8'h3F
`define IMG_MASK2_WMASK    8'h0E
`define IMG_FLAG0_USED     8'h0B
`define IMG_FLAG1_USED     8'h3F
`define IMG_FLAG2_USED     8'h0E
`define IMG_BYTE_RESET     8'h00

`endif

// ---- img_flag_bank.sv ----
// Purpose: One condition-flag register with latched or self-clearing behaviour
// Assumes: Conditions are levels synchronous to clk_sys
// Notes:   Set beats a read-clear in the same cycle
`timescale 1ns/10ps
module img_flag_bank #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] condIn,
  input  wire logic             selfClear,
  input  wire logic             readClear,
  output logic      [WIDTH-1:0] flag_q
);

  generate
    if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
      $error("img_flag_bank: WIDTH must be 1 to 8");
    end
  endgenerate

  // ==========================================================
  // Flag update
  // A condition present in the clearing cycle keeps the flag set, so no event is lost
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag_q <= '0;
    end else if (selfClear) begin
      flag_q <= condIn;                                       // see RULE4
    end else if (readClear) begin
      flag_q <= condIn;                                       // see RULE7
    end else begin
      flag_q <= flag_q | condIn;                              // see RULE3
    end
  end

  // ==========================================================
  // Checks
  chk_latched_hold : assert property (@(posedge clk_sys) disable iff (rst) // see RULE3
    (!selfClear && !readClear) |=> ((flag_q & $past(flag_q)) == $past(flag_q)))
    else $error("latched flag dropped without a read");

  chk_self_clear : assert property (@(posedge clk_sys) disable iff (rst) // see RULE4
    selfClear |=> (flag_q == $past(condIn)))
    else $error("self-clearing flag does not follow its condition");

  chk_set_wins : assert property (@(posedge clk_sys) disable iff (rst) // see RULE7
    (readClear && !selfClear) |=> ((flag_q & $past(condIn)) == $past(condIn)))
    else $error("condition lost during read clear");

endmodule : img_flag_bank

// ---- img_host_model.sv ----
// Purpose: Host processor model on the register port
// Assumes: Requests start just after a rising edge
// Notes:   Released address and data show the inverse of the last value
`timescale 1ns/10ps
module img_host_model (
  input  wire logic       clk_sys,
  output logic      [7:0] regAddr,
  output logic            regWrEn,
  output logic      [7:0] regWrData,
  output logic            regRdEn,
  input  wire logic [7:0] regRdData_q,
  input  wire logic       regRdValid_q
);
  // ==========================================
  // Register access
  initial begin
    regAddr   = 8'h00;
    regWrEn   = 1'b0;
    regWrData = 8'h00;
    regRdEn   = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge clk_sys);
    regWrEn   <= 1'b0;
    regAddr   <= ~a;
    regWrData <= ~d;
  endtask : wr

  // Answer is sampled just after the taking edge, so a late design shows no valid
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    #1;
    v = regRdValid_q;
    d = regRdData_q;
  endtask : rd
endmodule : img_host_model

// ---- img_irq_gate.sv ----
// Contract
// RULE1 - RW enable registers at 0x7, 0x8, 0x9 pick which paired flags may raise the interrupt.
// RULE2 - The interrupt is raised only by a set flag whose enable bit is one.
// RULE3 - With the self-clear bit (enable 0, bit 7) at zero, a set flag stays set until read.
// RULE4 - With self-clear at one, a flag clears by itself once its condition goes away.
// RULE5 - Enable 0: bit 3 attach status, bit 1 attach event, bit 0 measure done, all reset to 0.
// RULE6 - Enable 1: bits 5 to 0 gate limit UV, current limit, OV, UV, short and thermal, reset 0.
// RULE7 - Condition register 0 is read-only, and in latched mode a read clears all its flags; a flag with its condition present stays set.
// RULE8 - The interrupt is the OR of flag AND enable over all groups, one cycle after any change.
//
// Purpose: Enable registers, condition flags and gated interrupt output
// Assumes: Register port and condition inputs synchronous to clk_sys
// Notes:   Read data is registered and valid one cycle after the read strobe
`timescale 1ns/10ps
`include "img_defs.svh"
module img_irq_gate #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic              regWrEn,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regRdEn,
  input  wire logic [7:0]        condGroup0,
  input  wire logic [7:0]        condGroup1,
  input  wire logic [7:0]        condGroup2,
  output logic      [7:0]        regRdData_q,
  output logic                   regRdValid_q,
  output logic                   irqOut_q
);

  generate
    if (ADDR_W < 4 || ADDR_W > 8) begin : g_bad_addr
      $error("img_irq_gate: ADDR_W must be 4 to 8");
    end
  endgenerate

  // ==========================================================
  // Decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] target);
    hit = (a == target[ADDR_W-1:0]);
  endfunction : hit

  img_pkg::img_byte_t enableGroup0_q;
  img_pkg::img_byte_t enableGroup1_q;
  img_pkg::img_byte_t enableGroup2_q;
  img_pkg::img_byte_t flagGroup0;
  img_pkg::img_byte_t flagGroup1;
  img_pkg::img_byte_t flagGroup2;
  logic               selfClear;
  logic               rdFlag0;
  logic               rdFlag1;
  logic               rdFlag2;
  logic               irqNext;

  assign selfClear = enableGroup0_q[`IMG_SELF_CLR_BIT];
  assign rdFlag0   = regRdEn && hit(regAddr, `IMG_ADDR_FLAG0);
  assign rdFlag1   = regRdEn && hit(regAddr, `IMG_ADDR_FLAG1);
  assign rdFlag2   = regRdEn && hit(regAddr, `IMG_ADDR_FLAG2);

  // ==========================================================
  // Enable registers
  // Unused bits are not stored so they read back as zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      enableGroup0_q <= `IMG_BYTE_RESET;                      // see RULE5
      enableGroup1_q <= `IMG_BYTE_RESET;                      // see RULE6
      enableGroup2_q <= `IMG_BYTE_RESET;
    end else if (regWrEn) begin
      if (hit(regAddr, `IMG_ADDR_MASK0)) begin
        enableGroup0_q <= regWrData & `IMG_MASK0_WMASK;       // see RULE1
      end
      if (hit(regAddr, `IMG_ADDR_MASK1)) begin
        enableGroup1_q <= regWrData & `IMG_MASK1_WMASK;       // see RULE1
      end
      if (hit(regAddr, `IMG_ADDR_MASK2)) begin
        enableGroup2_q <= regWrData & `IMG_MASK2_WMASK;       // see RULE1
      end
    end
  end

  // ==========================================================
  // Condition flags; writes to them are ignored
  img_flag_bank #(.WIDTH(8)) u_flag0 (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .condIn    (condGroup0 & `IMG_FLAG0_USED),
    .selfClear (selfClear),
    .readClear (rdFlag0),                                     // see RULE7
    .flag_q    (flagGroup0)
  );

  img_flag_bank #(.WIDTH(8)) u_flag1 (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .condIn    (condGroup1 & `IMG_FLAG1_USED),
    .selfClear (selfClear),
    .readClear (rdFlag1),
    .flag_q    (flagGroup1)
  );

  img_flag_bank #(.WIDTH(8)) u_flag2 (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .condIn    (condGroup2 & `IMG_FLAG2_USED),
    .selfClear (selfClear),
    .readClear (rdFlag2),
    .flag_q    (flagGroup2)
  );

  // ==========================================================
  // Interrupt output
  // Registered so the pin never glitches; costs one cycle of latency
  assign irqNext = |(flagGroup0 & enableGroup0_q & `IMG_FLAG0_USED)   // see RULE2
                 | |(flagGroup1 & enableGroup1_q)
                 | |(flagGroup2 & enableGroup2_q);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqOut_q <= 1'b0;
    end else begin
      irqOut_q <= irqNext;                                    // see RULE8
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdData_q  <= `IMG_BYTE_RESET;
      regRdValid_q <= 1'b0;
    end else begin
      regRdValid_q <= regRdEn;
      if (regRdEn) begin
        if (hit(regAddr, `IMG_ADDR_MASK0)) begin
          regRdData_q <= enableGroup0_q;
        end else if (hit(regAddr, `IMG_ADDR_MASK1)) begin
          regRdData_q <= enableGroup1_q;
        end else if (hit(regAddr, `IMG_ADDR_MASK2)) begin
          regRdData_q <= enableGroup2_q;
        end else if (rdFlag0) begin
          regRdData_q <= flagGroup0;
        end else if (rdFlag1) begin
          regRdData_q <= flagGroup1;
        end else if (rdFlag2) begin
          regRdData_q <= flagGroup2;
        end else begin
          regRdData_q <= `IMG_BYTE_RESET;
        end
      end
    end
  end

  // ==========================================================
  // Checks
  sequence s_readFlag0Latched;
    rdFlag0 && !selfClear;
  endsequence

  sequence s_writeMask0;
    regWrEn && hit(regAddr, `IMG_ADDR_MASK0);
  endsequence

  chk_mask_write : assert property (@(posedge clk_sys) disable iff (rst) // see RULE1
    s_writeMask0 |=> (enableGroup0_q == ($past(regWrData) & `IMG_MASK0_WMASK)))
    else $error("enable group 0 did not take the write");

  chk_irq_gating : assert property (@(posedge clk_sys) disable iff (rst) // see RULE2
    (((flagGroup0 & enableGroup0_q & `IMG_FLAG0_USED) == `IMG_BYTE_RESET)
     && ((flagGroup1 & enableGroup1_q) == `IMG_BYTE_RESET)
     && ((flagGroup2 & enableGroup2_q) == `IMG_BYTE_RESET)) |=> !irqOut_q)
    else $error("interrupt raised without an enabled flag");

  chk_irq_timing : assert property (@(posedge clk_sys) disable iff (rst) // see RULE8
    irqNext |=> irqOut_q)
    else $error("interrupt missed its update cycle");

  chk_mask0_fields : assert property (@(posedge clk_sys) disable iff (rst) // see RULE5
    (enableGroup0_q & ~`IMG_MASK0_WMASK) == `IMG_BYTE_RESET)
    else $error("unused bit set in enable group 0");

  chk_mask1_fields : assert property (@(posedge clk_sys) disable iff (rst) // see RULE6
    (enableGroup1_q & ~`IMG_MASK1_WMASK) == `IMG_BYTE_RESET)
    else $error("unused bit set in enable group 1");

  chk_read_clear : assert property (@(posedge clk_sys) disable iff (rst) // see RULE7
    s_readFlag0Latched ##0 (condGroup0 == `IMG_BYTE_RESET) |=> (flagGroup0 == `IMG_BYTE_RESET))
    else $error("read of condition group 0 did not clear it");

  chk_read_data : assert property (@(posedge clk_sys) disable iff (rst) // see RULE7
    rdFlag0 |=> regRdValid_q && (regRdData_q == $past(flagGroup0)))
    else $error("read data of condition group 0 wrong");

endmodule : img_irq_gate

// ---- img_pkg.sv ----
// Purpose: Shared types of the interrupt gating block
// Assumes: Nothing beyond the defs header
// Notes:   Constants live in img_defs.svh
package img_pkg;
  typedef logic [7:0] img_byte_t;
  typedef enum logic [1:0] {
    IMG_GRP0 = 2'h0,
    IMG_GRP1 = 2'h1,
    IMG_GRP2 = 2'h2
  } img_group_t;
endpackage : img_pkg

// ---- test_interrupt_mask_gating.sv ----
// Purpose: Self-checking bench of the interrupt gating block
// Assumes: Host model drives the register port
// Notes:   Conditions are pulsed for one cycle except in the self-clear and set-beats-read tests
`timescale 1ns/10ps
module test_interrupt_mask_gating;
  logic       clk_sys;
  logic       rst;
  logic [7:0] regAddr;
  logic       regWrEn;
  logic [7:0] regWrData;
  logic       regRdEn;
  logic [7:0] cond [3];
  logic [7:0] regRdData_q;
  logic       regRdValid_q;
  logic       irqOut_q;
  logic [7:0] rdData;
  logic       rdValid;
  int         err_total;
  int         num_checks;

  img_irq_gate img_irq_gate_i (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .condGroup0(cond[0]),
    .condGroup1(cond[1]), .condGroup2(cond[2]), .regRdData_q(regRdData_q),
    .regRdValid_q(regRdValid_q), .irqOut_q(irqOut_q));
  img_host_model img_host_model_i (.clk_sys(clk_sys), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_q(regRdData_q),
    .regRdValid_q(regRdValid_q));

  // ==========================================
  // Helpers
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic chkByte(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chkByte

  task automatic chkBit(string n, logic e, logic g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask : chkBit

  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic rdChk(string n, logic [7:0] a, logic [7:0] e);
    img_host_model_i.rd(a, rdData, rdValid);
    chkBit(n, 1'b1, rdValid);
    chkByte(n, e, rdData);
  endtask : rdChk

  task automatic pulse(logic [1:0] g, int b);
    @(posedge clk_sys);
    cond[g][b] <= 1'b1;
    @(posedge clk_sys);
    cond[g][b] <= 1'b0;
  endtask : pulse

  // ==========================================
  // Scenarios
  task automatic t_regs();
    chkBit("irq at reset", 1'b0, irqOut_q);
    rdChk("mask0 reset", 8'h07, 8'h00);
    rdChk("mask1 reset", 8'h08, 8'h00);
    for (int i = 7; i <= 10; i++) img_host_model_i.wr(8'(i), 8'hFF);
    rdChk("mask0 rw", 8'h07, 8'h8B);
    rdChk("mask1 rw", 8'h08, 8'h3F);
    rdChk("mask2 rw", 8'h09, 8'h0E);
    rdChk("flag0 read only", 8'h0A, 8'h00);
    rdChk("unmapped", 8'h30, 8'h00);
    chkBit("irq no flags", 1'b0, irqOut_q);
    for (int i = 7; i <= 9; i++) img_host_model_i.wr(8'(i), 8'h00);
    $display("t_regs done");
  endtask : t_regs

  // Masked pass first, so the flag is proven set yet kept out of the interrupt
  task automatic t_gate(logic [1:0] g, int b);
    logic [7:0] bit8;
    bit8 = 8'h01 << b;
    pulse(g, b);
    cyc(3);
    chkBit("irq masked", 1'b0, irqOut_q);
    rdChk("flag masked", 8'h0A + 8'(g), bit8);
    img_host_model_i.wr(8'h07 + 8'(g), bit8);
    pulse(g, b);
    cyc(3);
    chkBit("irq latched", 1'b1, irqOut_q);
    rdChk("flag latched", 8'h0A + 8'(g), bit8);
    cyc(1);
    chkBit("irq after read", 1'b0, irqOut_q);
    img_host_model_i.wr(8'h07 + 8'(g), 8'h00);
    $display("t_gate done group %0d bit %0d", g, b);
  endtask : t_gate

  task automatic t_selfclr();
    img_host_model_i.wr(8'h07, 8'h81);
    @(posedge clk_sys);
    cond[0][0] <= 1'b1;
    cyc(3);
    chkBit("irq self clear", 1'b1, irqOut_q);
    rdChk("flag self clear", 8'h0A, 8'h01);
    cyc(2);
    chkBit("irq kept on read", 1'b1, irqOut_q);
    @(posedge clk_sys);
    cond[0][0] <= 1'b0;
    cyc(3);
    chkBit("irq gone", 1'b0, irqOut_q);
    rdChk("flag self cleared", 8'h0A, 8'h00);
    img_host_model_i.wr(8'h07, 8'h00);
    $display("t_selfclr done");
  endtask : t_selfclr

  // A condition still present at the read edge must survive the read
  task automatic t_setwins();
    img_host_model_i.wr(8'h08, 8'h01);
    @(posedge clk_sys);
    cond[1][0] <= 1'b1;
    cyc(2);
    fork
      rdChk("flag held on read", 8'h0B, 8'h01);
      begin
        repeat (2) @(posedge clk_sys);
        cond[1][0] <= 1'b0;
      end
    join
    cyc(2);
    chkBit("irq held on read", 1'b1, irqOut_q);
    rdChk("flag kept by read", 8'h0B, 8'h01);
    rdChk("flag cleared", 8'h0B, 8'h00);
    img_host_model_i.wr(8'h08, 8'h00);
    $display("t_setwins done");
  endtask : t_setwins

  initial begin
    err_total  = 0;
    num_checks = 0;
    rst        = 1'b1;
    cond[0]    = 8'h00;
    cond[1]    = 8'h00;
    cond[2]    = 8'h00;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(1);
    t_regs();
    for (int b = 0; b < 6; b++) t_gate(2'h1, b);
    t_gate(2'h0, 0);
    t_gate(2'h0, 1);
    t_gate(2'h0, 3);
    for (int b = 1; b < 4; b++) t_gate(2'h2, b);
    t_setwins();
    t_selfclr();
    end_sim();
  end

  initial begin
    #200000;
    err_total++;
    $display("Watchdog expired");
    end_sim();
  end
endmodule : test_interrupt_mask_gating
